// >>> hdl/apset_pkg.sv
// Purpose: Shared constants, types and decoders for the axis position preset block.
// Assumes: Positions are 64-bit signed fixed-point counts in user units.
// Notes:   Fault code values are arbitrary and may be remapped by the system.

`default_nettype none

package apset_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int POS_W   = 64;
  localparam int AXIS_W  = 6;
  localparam int FAULT_W = 16;

  // ---------------------------------------------------------------------------
  // Axis numbering and reference choices
  // ---------------------------------------------------------------------------
  localparam logic [AXIS_W-1:0] AXIS_FIRST    = 6'h01;
  localparam logic [AXIS_W-1:0] AXIS_LAST     = 6'h20;
  localparam logic              REF_COMMANDED = 1'b0;
  localparam logic              REF_MEASURED  = 1'b1;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [POS_W-1:0]   POS_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [AXIS_W-1:0]  AXIS_RESET = 6'h00;

  // The fault code values are arbitrary.
  localparam logic [FAULT_W-1:0] FAULT_NONE        = 16'h0000;
  localparam logic [FAULT_W-1:0] FAULT_AXIS_RANGE  = 16'h0001;
  localparam logic [FAULT_W-1:0] FAULT_REF_UNSUPP  = 16'h0002;
  localparam logic [FAULT_W-1:0] FAULT_HALT_ACTIVE = 16'h0003;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    AXIS_REAL     = 2'h0,
    AXIS_ENCODER  = 2'h1,
    AXIS_VIRTUAL  = 2'h2,
    AXIS_RESERVED = 2'h3
  } apset_axis_kind_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_BUSY = 3'h2,
    ST_HOLD = 3'h4
  } apset_state_type;

  // ---------------------------------------------------------------------------
  // Decoders
  // ---------------------------------------------------------------------------
  function automatic logic apset_axis_ok(input logic [AXIS_W-1:0] axis);
    return (axis >= AXIS_FIRST) && (axis <= AXIS_LAST);
  endfunction

  // Every defined axis kind supports both references; the reserved code none.
  function automatic logic apset_ref_ok(input apset_axis_kind_type kind, input logic sel);
    logic ok;
    ok = 1'b0;
    unique case (kind)
      AXIS_REAL, AXIS_ENCODER, AXIS_VIRTUAL: ok = (sel == REF_COMMANDED) || (sel == REF_MEASURED);
      AXIS_RESERVED:                         ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

`default_nettype wire

// >>> hdl/apset_calc_if.sv
// Purpose: Carries sampled preset operands to the position calculator and back.
// Assumes: Purely combinational traffic inside one clock domain.
// Notes:   The calculator reads operands and returns results through the calc modport.

`timescale 1ns/1ps
`default_nettype none

interface apset_calc_if;
  import apset_pkg::*;
  logic signed [POS_W-1:0] ref_commanded;
  logic signed [POS_W-1:0] ref_measured;
  logic signed [POS_W-1:0] position;
  logic                    relative;
  logic                    reference_select;
  logic signed [POS_W-1:0] target;
  logic signed [POS_W-1:0] shift;

  modport calc (
    input  ref_commanded, ref_measured, position, relative, reference_select,
    output target, shift
  );
  modport user (
    output ref_commanded, ref_measured, position, relative, reference_select,
    input  target, shift
  );
endinterface

`default_nettype wire

// >>> hdl/apset_calc.sv
// Purpose: Computes the preset target and the common shift for both positions.
// Assumes: Operands were sampled when the preset began.
// Notes:   Overflow wraps in two's complement; no saturation.

`timescale 1ns/1ps
`default_nettype none

module apset_calc
  import apset_pkg::*;
(
  // Operands and results
  apset_calc_if.calc bus
);

  logic signed [POS_W-1:0] ref_value;

  always_comb begin
    ref_value = (bus.reference_select == REF_MEASURED) ? bus.ref_measured
                                                       : bus.ref_commanded;
    bus.target = bus.relative ? POS_W'(ref_value + bus.position)
                              : bus.position;
    // The same shift goes to both positions, whichever one is the reference.
    bus.shift  = POS_W'(bus.target - ref_value);
  end

endmodule

`default_nettype wire

// >>> hdl/apset_top.sv
// Purpose: Axis position preset; rewrites an axis's positions without moving it.
// Assumes: period_tick_in pulses once per control period; inputs are synchronous.
// Notes:   The axis state applies preset_shift_out to both of its positions.
//
// What this block does
// - Trigger rise: busy; next period done, busy off.
// - Error: flag, code, busy off together.
// - Error held until trigger falls.
// - Overwrite position only, no axis motion.
// - Running motion unaffected by preset.
// - Reference sampled when preset starts.
// - Relative: target is reference plus position.
// - Absolute: target is requested position.
// - Selector 0: commanded position is reference.
// - Selector 1: measured position is reference.
// - Measured shifts with commanded; deviation kept.
// - Measured reference handled symmetrically.
// - Unsupported reference for axis kind errors.
// - Master preset never reaches slave axes.
// - Slave preset keeps coupling intact.
// - Preset during halt instruction is rejected.
// - After halt completes, presets work normally.
// - Done held while trigger high.
// - Trigger gone early: done one period.

`timescale 1ns/1ps
`default_nettype none

module apset_top
  import apset_pkg::*;
(
  // Clock and reset
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  // Control period
  input  wire logic                     period_tick_in,
  // Preset request
  input  wire logic                     trigger_in,
  input  wire logic [AXIS_W-1:0]        axis_num_in,
  input  wire logic signed [POS_W-1:0]  position_in,
  input  wire logic                     relative_in,
  input  wire logic                     reference_select_in,
  // Axis state
  input  wire logic [1:0]               axis_kind_in,
  input  wire logic                     halt_active_in,
  input  wire logic signed [POS_W-1:0]  ref_commanded_in,
  input  wire logic signed [POS_W-1:0]  ref_measured_in,
  // Handshake
  output logic                          busy_out,
  output logic                          done_out,
  output logic                          error_out,
  output logic [FAULT_W-1:0]            fault_code_out,
  // Position update
  output logic                          preset_write_out,
  output logic [AXIS_W-1:0]             preset_axis_out,
  output logic signed [POS_W-1:0]       preset_target_out,
  output logic signed [POS_W-1:0]       preset_shift_out
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  apset_state_type          state_reg;
  apset_state_type          state_next;
  logic                     trig_prev_reg;
  logic                     busy_reg;
  logic                     done_reg;
  logic                     error_reg;
  logic [FAULT_W-1:0]       fault_code_reg;
  logic [AXIS_W-1:0]        axis_reg;
  apset_axis_kind_type      kind_reg;
  logic signed [POS_W-1:0]  pos_reg;
  logic                     rel_reg;
  logic                     sel_reg;
  logic signed [POS_W-1:0]  ref_cmd_reg;
  logic signed [POS_W-1:0]  ref_meas_reg;
  logic                     write_reg;
  logic signed [POS_W-1:0]  target_reg;
  logic signed [POS_W-1:0]  shift_reg;
  logic                     trig_rise;
  logic                     start;
  logic                     finish;
  logic                     release_hold;
  logic [FAULT_W-1:0]       fault_next;

  apset_calc_if calc_bus();

  // ---------------------------------------------------------------------------
  // Period events
  // ---------------------------------------------------------------------------
  // The trigger is judged only at period ticks, so a pulse narrower than a
  // control period is seen only if it is high at a tick; the program runs on that same period.
  assign trig_rise    = period_tick_in && trigger_in && !trig_prev_reg;
  assign start        = trig_rise && (state_reg == ST_IDLE);
  assign finish       = period_tick_in && (state_reg == ST_BUSY);
  assign release_hold = period_tick_in && (state_reg == ST_HOLD) && !trigger_in;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      trig_prev_reg <= 1'b0;
    end else if (period_tick_in) begin
      trig_prev_reg <= trigger_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (finish) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (release_hold) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Operand capture
  // ---------------------------------------------------------------------------
  // All operands but the halt status are latched at the rising tick so later changes of the request
  // or of the live positions cannot alter a preset already under way.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      axis_reg     <= AXIS_RESET;
      kind_reg     <= AXIS_REAL;
      pos_reg      <= POS_RESET;
      rel_reg      <= 1'b0;
      sel_reg      <= REF_COMMANDED;
      ref_cmd_reg  <= POS_RESET;
      ref_meas_reg <= POS_RESET;
    end else if (start) begin
      axis_reg     <= axis_num_in;
      kind_reg     <= apset_axis_kind_type'(axis_kind_in);
      pos_reg      <= position_in;
      rel_reg      <= relative_in;
      sel_reg      <= reference_select_in;
      ref_cmd_reg  <= ref_commanded_in;
      ref_meas_reg <= ref_measured_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Target calculation
  // ---------------------------------------------------------------------------
  assign calc_bus.ref_commanded    = ref_cmd_reg;
  assign calc_bus.ref_measured     = ref_meas_reg;
  assign calc_bus.position         = pos_reg;
  assign calc_bus.relative         = rel_reg;
  assign calc_bus.reference_select = sel_reg;

  apset_calc u_calc (
    .bus (calc_bus.calc)
  );

  // ---------------------------------------------------------------------------
  // Fault check
  // ---------------------------------------------------------------------------
  // The halt test uses the live status at completion: a halt still running
  // then rejects the preset, one already finished lets it through.
  always_comb begin
    fault_next = FAULT_NONE;
    if (!apset_axis_ok(axis_reg)) begin
      fault_next = FAULT_AXIS_RANGE;
    end else if (!apset_ref_ok(kind_reg, sel_reg)) begin
      fault_next = FAULT_REF_UNSUPP;
    end else if (halt_active_in) begin
      fault_next = FAULT_HALT_ACTIVE;
    end
  end

  // ---------------------------------------------------------------------------
  // Handshake flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
    end else if (start) begin
      busy_reg <= 1'b1;
    end else if (finish) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      done_reg <= 1'b0;
    end else if (finish) begin
      done_reg <= (fault_next == FAULT_NONE);
    end else if (release_hold) begin
      // A trigger already low at completion clears done one period later.
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      error_reg      <= 1'b0;
      fault_code_reg <= FAULT_NONE;
    end else if (finish) begin
      error_reg      <= (fault_next != FAULT_NONE);
      fault_code_reg <= fault_next;
    end else if (release_hold) begin
      error_reg      <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Position update
  // ---------------------------------------------------------------------------
  // Only the addressed axis is written, and no coupling information is
  // touched: masters do not pass the change on, slaves stay coupled.
  // No move request leaves this block; the shift is a pure offset so a
  // running profile keeps its velocity and its relative end point.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      write_reg <= 1'b0;
    end else begin
      write_reg <= finish && (fault_next == FAULT_NONE);
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      target_reg <= POS_RESET;
      shift_reg  <= POS_RESET;
    end else if (finish && (fault_next == FAULT_NONE)) begin
      // One shift for both positions in one strobe keeps the deviation whole.
      target_reg <= calc_bus.target;
      shift_reg  <= calc_bus.shift;
    end
  end

  assign busy_out          = busy_reg;
  assign done_out          = done_reg;
  assign error_out         = error_reg;
  assign fault_code_out    = fault_code_reg;
  assign preset_write_out  = write_reg;
  assign preset_axis_out   = axis_reg;
  assign preset_target_out = target_reg;
  assign preset_shift_out  = shift_reg;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking chk_clk @(posedge clock_in); endclocking
  default disable iff (rst_in);

  chk_busy_on_rise: assert property (
    start |=> busy_out && !done_out && !error_out
  ) else $error("busy did not rise on trigger");

  chk_done_next_tick: assert property (
    finish && (fault_next == FAULT_NONE) |=> done_out && !busy_out
  ) else $error("done and busy wrong at completion");

  chk_error_drops_busy: assert property (
    $rose(error_out) |-> !busy_out && (fault_code_out != FAULT_NONE) && !done_out
  ) else $error("error without code or with busy");

  chk_error_held: assert property (
    error_out && !(period_tick_in && !trigger_in) |=> error_out && $stable(fault_code_out)
  ) else $error("error dropped early");

  chk_error_clears: assert property (
    error_out && period_tick_in && !trigger_in |=> !error_out
  ) else $error("error not cleared on trigger fall");

  chk_abs_target: assert property (
    preset_write_out && !rel_reg |-> preset_target_out == pos_reg
  ) else $error("absolute target differs from position");

  chk_rel_target: assert property (
    preset_write_out && rel_reg |->
      preset_target_out == POS_W'(pos_reg + (sel_reg ? ref_meas_reg : ref_cmd_reg))
  ) else $error("relative target wrong");

  chk_shift_keeps_dev: assert property (
    preset_write_out |->
      POS_W'(preset_target_out - preset_shift_out) == (sel_reg ? ref_meas_reg : ref_cmd_reg)
  ) else $error("shift does not match reference");

  chk_halt_rejects: assert property (
    finish && halt_active_in |=> error_out && !preset_write_out ##1 !preset_write_out
  ) else $error("preset accepted during halt");

  chk_done_held: assert property (
    done_out && trigger_in |=> done_out
  ) else $error("done dropped while trigger high");

  chk_write_single: assert property (
    preset_write_out |=> !preset_write_out
  ) else $error("write strobe longer than one cycle");

  cov_normal_done:  cover property (finish && (fault_next == FAULT_NONE) ##1 done_out);
  cov_halt_error:   cover property (finish && halt_active_in ##1 error_out);
  cov_measured_rel: cover property (preset_write_out && sel_reg && rel_reg);
  cov_early_fall:   cover property (busy_out && period_tick_in && !trigger_in);

endmodule

`default_nettype wire

// >>> bench/apset_axis_model.sv
// Purpose: Axis position state facing the preset block.
// Assumes: Motion moves both positions by vel_in once per control period.
// Notes:   A load from the bench wins over motion and preset in the same clock.

`timescale 1ns/1ps
`default_nettype none

module apset_axis_model
  import apset_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    rst_in,
  // Motion and preset
  input  wire logic                    period_tick_in,
  input  wire logic signed [POS_W-1:0] vel_in,
  input  wire logic                    write_in,
  input  wire logic signed [POS_W-1:0] shift_in,
  // Bench load
  input  wire logic                    load_in,
  input  wire logic signed [POS_W-1:0] load_cmd_in,
  input  wire logic signed [POS_W-1:0] load_meas_in,
  // Positions
  output logic signed [POS_W-1:0]      ref_commanded_out,
  output logic signed [POS_W-1:0]      ref_measured_out
);
  // ---------------------------------------------------------------------------
  // Position state
  // ---------------------------------------------------------------------------
  // The preset only shifts; running motion keeps its own step each period.
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ref_commanded_out <= POS_RESET;
      ref_measured_out  <= POS_RESET;
    end else if (load_in) begin
      ref_commanded_out <= load_cmd_in;
      ref_measured_out  <= load_meas_in;
    end else if (write_in) begin
      ref_commanded_out <= ref_commanded_out + shift_in;
      ref_measured_out  <= ref_measured_out + shift_in;
    end else if (period_tick_in) begin
      ref_commanded_out <= ref_commanded_out + vel_in;
      ref_measured_out  <= ref_measured_out + vel_in;
    end
  end
endmodule

`default_nettype wire

// >>> bench/apset_top_tb.sv
// Purpose: Self-checking bench for the axis position preset block.
// Assumes: One control period is four clocks; inputs change on falling edges.
// Notes:   The axis moves during every preset to show the shift keeps deviation.

`timescale 1ns/1ps
`default_nettype none

module apset_top_tb;
  import apset_pkg::*;
  localparam int                      PERIOD_CLKS = 4;
  localparam int                      LIMIT       = 3000;
  localparam logic signed [POS_W-1:0] VEL         = 64'h64;

  logic                    clock_in, rst_in, period_tick_in, trigger_in, relative_in;
  logic                    reference_select_in, halt_active_in, load;
  logic [AXIS_W-1:0]       axis_num_in, preset_axis_out;
  logic [1:0]              axis_kind_in;
  logic signed [POS_W-1:0] position_in, load_cmd, load_meas, cmd, meas, target, shift;
  logic                    busy_out, done_out, error_out, write;
  logic [FAULT_W-1:0]      fault_code_out;
  int                      n_errors, comparisons, cycles, tick_cnt;

  apset_top apset_top_inst (.clock_in(clock_in), .rst_in(rst_in), .period_tick_in(period_tick_in),
    .trigger_in(trigger_in), .axis_num_in(axis_num_in), .position_in(position_in),
    .relative_in(relative_in), .reference_select_in(reference_select_in), .axis_kind_in(axis_kind_in),
    .halt_active_in(halt_active_in), .ref_commanded_in(cmd), .ref_measured_in(meas),
    .busy_out(busy_out), .done_out(done_out), .error_out(error_out), .fault_code_out(fault_code_out),
    .preset_write_out(write), .preset_axis_out(preset_axis_out), .preset_target_out(target),
    .preset_shift_out(shift));

  apset_axis_model apset_axis_model_inst (.clock_in(clock_in), .rst_in(rst_in),
    .period_tick_in(period_tick_in), .vel_in(VEL), .write_in(write), .shift_in(shift), .load_in(load),
    .load_cmd_in(load_cmd), .load_meas_in(load_meas), .ref_commanded_out(cmd), .ref_measured_out(meas));

  // ---------------------------------------------------------------------------
  // Clock, period strobe and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  always @(negedge clock_in) begin
    period_tick_in <= (tick_cnt == PERIOD_CLKS - 1);
    tick_cnt       <= (tick_cnt + 1) % PERIOD_CLKS;
  end

  always @(posedge clock_in) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      n_errors = n_errors + 1;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic check(input logic [POS_W-1:0] seen, input logic [POS_W-1:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick_edge();
    @(posedge clock_in iff period_tick_in);
    #1;
  endtask

  // One whole preset; the trigger rises only after a tick that saw it low.
  task automatic do_preset(input logic [AXIS_W-1:0] ax, input logic [1:0] kind, input logic rel,
                           input logic sel, input logic signed [POS_W-1:0] pos, input logic halt,
                           input logic [FAULT_W-1:0] code, input logic early);
    logic signed [POS_W-1:0] c0, m0, rf, tg;
    @(negedge clock_in);
    load      = 1'b1;
    load_cmd  = 64'hBB8;
    load_meas = 64'h8FC;
    @(negedge clock_in);
    load = 1'b0;
    tick_edge();
    @(negedge clock_in);
    c0 = cmd;
    m0 = meas;
    rf = sel ? m0 : c0;
    tg = rel ? rf + pos : pos;
    axis_num_in         = ax;
    axis_kind_in        = kind;
    relative_in         = rel;
    reference_select_in = sel;
    position_in         = pos;
    halt_active_in      = halt;
    trigger_in          = 1'b1;
    tick_edge();
    check(busy_out, 1'b1);
    check(done_out | error_out, 1'b0);
    if (early) begin
      @(negedge clock_in);
      trigger_in = 1'b0;
    end
    tick_edge();
    check(busy_out, 1'b0);
    check(done_out, code == FAULT_NONE);
    check(error_out, code != FAULT_NONE);
    check(fault_code_out, code);
    check(write, code == FAULT_NONE);
    if (code == FAULT_NONE) begin
      check(target, tg);
      check(shift, tg - rf);
      check(preset_axis_out, ax);
    end
    @(posedge clock_in);
    #1;
    check(write, 1'b0);
    check(cmd, c0 + 2 * VEL + ((code == FAULT_NONE) ? tg - rf : 64'h0));
    check((sel ? meas : cmd) - 2 * VEL, (code == FAULT_NONE) ? tg : rf);
    check(meas - cmd, m0 - c0);
    tick_edge();
    check(done_out | error_out, !early);
    @(negedge clock_in);
    trigger_in     = 1'b0;
    halt_active_in = 1'b0;
    tick_edge();
    check(done_out | error_out, 1'b0);
    check(fault_code_out, code);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_absolute_commanded();
    do_preset(6'h01, 2'h0, 1'b0, REF_COMMANDED, 64'h1770, 1'b0, FAULT_NONE, 1'b0);
  endtask

  task automatic t_relative_measured();
    do_preset(6'h20, 2'h1, 1'b1, REF_MEASURED, 64'h1388, 1'b0, FAULT_NONE, 1'b0);
  endtask

  // Every supported kind with both references and both modes.
  task automatic t_kind_table();
    for (int k = 0; k < 3; k++) begin
      for (int s = 0; s < 4; s++) begin
        do_preset(6'h05, k[1:0], s[1], s[0], -64'sh3E8, 1'b0, FAULT_NONE, 1'b0);
      end
    end
  endtask

  task automatic t_faults();
    do_preset(6'h00, 2'h0, 1'b0, REF_COMMANDED, 64'h10, 1'b0, FAULT_AXIS_RANGE, 1'b0);
    do_preset(6'h21, 2'h0, 1'b0, REF_COMMANDED, 64'h10, 1'b0, FAULT_AXIS_RANGE, 1'b0);
    do_preset(6'h03, 2'h3, 1'b1, REF_MEASURED, 64'h10, 1'b0, FAULT_REF_UNSUPP, 1'b0);
  endtask

  task automatic t_halt_then_clear();
    do_preset(6'h02, 2'h2, 1'b1, REF_COMMANDED, 64'h20, 1'b1, FAULT_HALT_ACTIVE, 1'b0);
    do_preset(6'h02, 2'h2, 1'b1, REF_COMMANDED, 64'h20, 1'b0, FAULT_NONE, 1'b0);
  endtask

  task automatic t_early_release();
    do_preset(6'h07, 2'h0, 1'b1, REF_MEASURED, 64'h40, 1'b0, FAULT_NONE, 1'b1);
    do_preset(6'h07, 2'h3, 1'b0, REF_COMMANDED, 64'h40, 1'b0, FAULT_REF_UNSUPP, 1'b1);
  endtask

  // A reset in mid-preset must drop every handshake output and the write strobe.
  task automatic t_reset_midrun();
    tick_edge();
    @(negedge clock_in);
    trigger_in = 1'b1;
    tick_edge();
    check(busy_out, 1'b1);
    @(negedge clock_in);
    rst_in = 1'b1;
    @(negedge clock_in);
    rst_in     = 1'b0;
    trigger_in = 1'b0;
    check(busy_out | done_out | error_out | write, 1'b0);
    check(fault_code_out, FAULT_NONE);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    n_errors = 0; comparisons = 0; cycles = 0; tick_cnt = 0;
    rst_in = 1'b1; period_tick_in = 1'b0; trigger_in = 1'b0; load = 1'b0;
    axis_num_in = 6'h01; axis_kind_in = 2'h0; relative_in = 1'b0; reference_select_in = 1'b0;
    position_in = 64'h0; halt_active_in = 1'b0; load_cmd = 64'h0; load_meas = 64'h0;
    repeat (16) @(posedge clock_in);
    @(negedge clock_in);
    rst_in = 1'b0;
    t_absolute_commanded();
    t_relative_measured();
    t_kind_table();
    t_faults();
    t_halt_then_clear();
    t_early_release();
    t_reset_midrun();
    end_of_test();
  end
endmodule

`default_nettype wire
